// File: logic/sdi_rx_deserializer.sv
//
// Contract
// - Line flag high after EAV, low after SAV.
// - Decode bypass low decodes, high passes raw.
// - Equalizer bypass independent of decode bypass.
// - Lock rises about 38 us after words.
// - Ten-bit words with a word clock.
// - Ten serial bits grouped per word.
// - Carrier detect low while transitions present.
// - Valid words within 250 ms of header.
// - Re-lock within 10 us after switch.
// - NRZI decode then x^9+x^4+1 descramble.
// - Header resets the divide-by-ten divider.
// - Line flag undefined while decoding bypassed.
// - Lock may drop briefly, data unaffected; here lock drops only with alignment loss, which stops the word path.
`timescale 1ns/1ps
`default_nettype none
`include "sdi_rx_defs.svh"

module sdi_rx_deserializer #(
    parameter int unsigned LOCK_CYCLES =
        (`SDI_LOCK_TIME_NS * 1000) / `SDI_CLK_PERIOD_PS
) (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Recovered serial stream
    input wire logic ser_data,
    input wire logic ser_valid,
    // Parallel video output
    output logic [9:0] par_word,
    output logic par_word_clk,
    // Indications and controls
    output logic line_timing,
    output logic lock,
    output logic carrier_present_n,
    output logic equalizer_bypass_sel,
    output logic irq
);

    localparam int unsigned CD_IDLE_CYCLES =
        (`SDI_CD_IDLE_NS * 1000) / `SDI_CLK_PERIOD_PS;

    sdi_rx_pkg::ser_bit_t raw_bit;
    sdi_rx_pkg::ser_bit_t dec_bit;
    sdi_rx_pkg::align_state_t align_q;
    sdi_rx_pkg::ahb_dphase_t dph_q;

    logic decode_bypass_sel_q;
    logic eq_bypass_q;
    logic [`SDI_IRQ_WIDTH-1:0] irq_stat_q;
    logic [`SDI_IRQ_WIDTH-1:0] irq_mask_q;
    logic [`SDI_IRQ_WIDTH-1:0] irq_events;
    logic [`SDI_IRQ_WIDTH-1:0] irq_clear;

    logic [29:0] trs_win_q;
    logic [29:0] trs_win_d;
    logic trs_hit;
    logic trs_pend_q;
    logic [3:0] bit_cnt_q;
    logic [3:0] bit_cnt_d;
    logic [9:0] word_sh_q;
    logic [9:0] word_full;
    logic word_done;

    logic last_raw_q;
    logic [8:0] idle_cnt_q;
    logic carrier_q;
    logic carrier_loss_ev;
    logic [13:0] lock_cnt_q;
    logic lock_q;
    logic eav_ev;
    logic sav_ev;

    logic addr_take;
    logic [31:0] rd_value;

    // ======================================================================
    // Bit decoding.
    assign raw_bit = '{data: ser_data, valid: ser_valid};

    sdi_bit_decoder u_decoder (
        .hclk(hclk),
        .hresetn(hresetn),
        .bypass(decode_bypass_sel_q),
        .bit_in(raw_bit),
        .bit_out(dec_bit)
    );

    // ======================================================================
    // Carrier detect: a strobed raw bit that differs from the previous strobed bit restarts the idle count.
    assign carrier_loss_ev = carrier_q && (idle_cnt_q == 9'(CD_IDLE_CYCLES - 1));

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            last_raw_q <= 1'b0;
            idle_cnt_q <= 9'h000;
            carrier_q <= 1'b0;
        end else begin
            if (ser_valid) begin
                last_raw_q <= ser_data;
            end
            if (ser_valid && (ser_data != last_raw_q)) begin
                idle_cnt_q <= 9'h000;
                carrier_q <= 1'b1;
            end else if (carrier_q) begin
                if (carrier_loss_ev) begin
                    carrier_q <= 1'b0;
                    idle_cnt_q <= 9'h000;
                end else begin
                    idle_cnt_q <= idle_cnt_q + 9'h001;
                end
            end
        end
    end

    // ======================================================================
    // Timing reference search over the last thirty decoded bits.
    assign trs_win_d = {dec_bit.data, trs_win_q[29:1]};
    assign trs_hit = dec_bit.valid && (trs_win_d == `SDI_TRS_PATTERN);
    assign word_full = {dec_bit.data, word_sh_q[9:1]};
    assign word_done = dec_bit.valid && (bit_cnt_q == `SDI_LAST_BIT);
    assign eav_ev = word_done && trs_pend_q && word_full[`SDI_TRS_H_BIT];
    assign sav_ev = word_done && trs_pend_q && !word_full[`SDI_TRS_H_BIT];

    always_comb begin
        bit_cnt_d = bit_cnt_q;
        if (dec_bit.valid) begin
            if (trs_hit || bit_cnt_q == `SDI_LAST_BIT) begin
                bit_cnt_d = 4'h0;
            end else begin
                bit_cnt_d = bit_cnt_q + 4'h1;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            trs_win_q <= 30'h00000000;
            word_sh_q <= 10'h000;
            bit_cnt_q <= 4'h0;
        end else if (dec_bit.valid) begin
            trs_win_q <= trs_win_d;
            word_sh_q <= word_full;
            bit_cnt_q <= bit_cnt_d;
        end
    end

    // ======================================================================
    // Alignment state: every header realigns at once, so a switched
    // source is followed within one word of its first header.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            align_q <= sdi_rx_pkg::ALIGN_HUNT;
            trs_pend_q <= 1'b0;
        end else begin
            unique case (align_q)
                sdi_rx_pkg::ALIGN_HUNT: begin
                    if (trs_hit && carrier_q) begin
                        align_q <= sdi_rx_pkg::ALIGN_SYNC;
                    end
                end
                sdi_rx_pkg::ALIGN_SYNC: begin
                    if (!carrier_q) begin
                        align_q <= sdi_rx_pkg::ALIGN_HUNT;
                    end
                end
                default: begin
                    align_q <= sdi_rx_pkg::ALIGN_HUNT;
                end
            endcase
            if (trs_hit) begin
                trs_pend_q <= 1'b1;
            end else if (word_done) begin
                trs_pend_q <= 1'b0;
            end
        end
    end

    // ======================================================================
    // Parallel word, word clock and line timing flag.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            par_word <= 10'h000;
            par_word_clk <= 1'b0;
            line_timing <= 1'b0;
        end else begin
            if (word_done && align_q == sdi_rx_pkg::ALIGN_SYNC) begin
                par_word <= word_full;
            end
            par_word_clk <= (align_q == sdi_rx_pkg::ALIGN_SYNC)
                && (bit_cnt_d >= `SDI_PCLK_HIGH_FROM);
            // In bypass the flag follows raw bits and means nothing.
            if (eav_ev) begin
                line_timing <= 1'b1;
            end else if (sav_ev) begin
                line_timing <= 1'b0;
            end
        end
    end

    // ======================================================================
    // Lock indication, delayed after alignment; drops only when carrier
    // and alignment are lost, the same loss that stops par_word and par_word_clk.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            lock_cnt_q <= 14'h0000;
            lock_q <= 1'b0;
        end else if (align_q != sdi_rx_pkg::ALIGN_SYNC) begin
            lock_cnt_q <= 14'h0000;
            lock_q <= 1'b0;
        end else if (lock_cnt_q != 14'(LOCK_CYCLES - 1)) begin
            lock_cnt_q <= lock_cnt_q + 14'h0001;
        end else begin
            lock_q <= 1'b1;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            lock <= 1'b0;
            carrier_present_n <= 1'b1;
        end else begin
            lock <= lock_q;
            carrier_present_n <= !carrier_q;
        end
    end

    // ======================================================================
    // AHB-Lite slave, zero wait states, always OKAY.
    assign addr_take = hsel && hready && htrans[1];

    always_comb begin
        rd_value = 32'h00000000;
        unique case (haddr[7:0])
            `SDI_REG_CTRL: begin
                rd_value[`SDI_CTRL_DECODE_BYP] = decode_bypass_sel_q;
                rd_value[`SDI_CTRL_EQ_BYP] = eq_bypass_q;
            end
            `SDI_REG_STATUS: begin
                rd_value[`SDI_STAT_LINE_TIMING] = line_timing;
                rd_value[`SDI_STAT_LOCK] = lock_q;
                rd_value[`SDI_STAT_CARRIER] = carrier_q;
                rd_value[`SDI_STAT_ALIGNED] = (align_q == sdi_rx_pkg::ALIGN_SYNC);
            end
            `SDI_REG_IRQ_STATUS: begin
                rd_value[`SDI_IRQ_WIDTH-1:0] = irq_stat_q;
            end
            `SDI_REG_IRQ_MASK: begin
                rd_value[`SDI_IRQ_WIDTH-1:0] = irq_mask_q;
            end
            default: begin
                rd_value = 32'h00000000;
            end
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dph_q <= '0;
            hrdata <= 32'h00000000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            if (hready) begin
                dph_q.valid <= addr_take;
                dph_q.write <= hwrite;
                dph_q.offset <= haddr[7:0];
            end
            if (addr_take && !hwrite) begin
                hrdata <= rd_value;
            end
        end
    end

    // ======================================================================
    // Control register: both bypass selects are separate bits, giving
    // all four equalizer and decoder combinations.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            decode_bypass_sel_q <= 1'(`SDI_CTRL_RESET >> `SDI_CTRL_DECODE_BYP);
            eq_bypass_q <= 1'b0;
            equalizer_bypass_sel <= 1'b0;
            irq_mask_q <= `SDI_IRQ_MASK_RESET;
        end else begin
            if (dph_q.valid && dph_q.write && dph_q.offset == `SDI_REG_CTRL) begin
                decode_bypass_sel_q <= hwdata[`SDI_CTRL_DECODE_BYP];
                eq_bypass_q <= hwdata[`SDI_CTRL_EQ_BYP];
            end
            if (dph_q.valid && dph_q.write && dph_q.offset == `SDI_REG_IRQ_MASK) begin
                irq_mask_q <= hwdata[`SDI_IRQ_WIDTH-1:0];
            end
            equalizer_bypass_sel <= eq_bypass_q;
        end
    end

    // ======================================================================
    // Interrupts: sticky status, write one to clear, set wins over clear.
    always_comb begin
        irq_events = '0;
        irq_events[`SDI_IRQ_EAV] = eav_ev;
        irq_events[`SDI_IRQ_SAV] = sav_ev;
        irq_events[`SDI_IRQ_LOCK] = (lock_cnt_q == 14'(LOCK_CYCLES - 1)) && !lock_q
            && (align_q == sdi_rx_pkg::ALIGN_SYNC);
        irq_events[`SDI_IRQ_CARRIER_LOST] = carrier_loss_ev;
    end

    assign irq_clear = (dph_q.valid && dph_q.write && dph_q.offset == `SDI_REG_IRQ_STATUS)
        ? hwdata[`SDI_IRQ_WIDTH-1:0] : '0;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_stat_q <= '0;
            irq <= 1'b0;
        end else begin
            irq_stat_q <= (irq_stat_q & ~irq_clear) | irq_events;
            irq <= |(((irq_stat_q & ~irq_clear) | irq_events) & irq_mask_q);
        end
    end

endmodule

`default_nettype wire

// File: logic/sdi_rx_defs.svh
`ifndef SDI_RX_DEFS_SVH
`define SDI_RX_DEFS_SVH

// ==========================================================================
// Register offsets (byte addresses within the slave's window).
`define SDI_REG_CTRL 8'h00
`define SDI_REG_STATUS 8'h04
`define SDI_REG_IRQ_STATUS 8'h08
`define SDI_REG_IRQ_MASK 8'h0c

// ==========================================================================
// Field positions.
`define SDI_CTRL_DECODE_BYP 0
`define SDI_CTRL_EQ_BYP 1
`define SDI_STAT_LINE_TIMING 0
`define SDI_STAT_LOCK 1
`define SDI_STAT_CARRIER 2
`define SDI_STAT_ALIGNED 3
`define SDI_IRQ_EAV 0
`define SDI_IRQ_SAV 1
`define SDI_IRQ_LOCK 2
`define SDI_IRQ_CARRIER_LOST 3
`define SDI_IRQ_WIDTH 4

// ==========================================================================
// Reset values.
`define SDI_CTRL_RESET 2'h0
`define SDI_IRQ_MASK_RESET 4'h0

// ==========================================================================
// Stream constants.
`define SDI_WORD_BITS 10
`define SDI_TRS_PATTERN 30'h000003ff
`define SDI_TRS_H_BIT 6
`define SDI_LAST_BIT 4'h9
`define SDI_PCLK_HIGH_FROM 4'h5

// ==========================================================================
// Timing.
`define SDI_CLK_PERIOD_PS 4000
`define SDI_LOCK_TIME_NS 38000
`define SDI_CD_IDLE_NS 1000

`endif

// File: logic/sdi_rx_pkg.sv
package sdi_rx_pkg;

    // ======================================================================
    // One received serial bit with its strobe.
    typedef struct packed {
        logic data;
        logic valid;
    } ser_bit_t;

    // ======================================================================
    // Word alignment state.
    typedef enum logic [1:0] {
        ALIGN_HUNT = 2'b01,
        ALIGN_SYNC = 2'b10
    } align_state_t;

    // ======================================================================
    // Captured AHB address phase, used in the data phase.
    typedef struct packed {
        logic valid;
        logic write;
        logic [7:0] offset;
    } ahb_dphase_t;

endpackage

// File: logic/sdi_bit_decoder.sv
`timescale 1ns/1ps
`default_nettype none

// NRZI decoder followed by a self-synchronising descrambler, with bypass.
module sdi_bit_decoder (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Control
    input wire logic bypass,
    // Bit streams
    input wire sdi_rx_pkg::ser_bit_t bit_in,
    output sdi_rx_pkg::ser_bit_t bit_out
);

    logic prev_raw_q;
    logic [8:0] nrz_hist_q;
    logic nrz;
    logic descr;

    // ======================================================================
    // NRZI decode inverts x + 1; descrambling inverts x^9 + x^4 + 1.
    assign nrz = bit_in.data ^ prev_raw_q;
    assign descr = nrz ^ nrz_hist_q[3] ^ nrz_hist_q[8];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            prev_raw_q <= 1'b0;
            nrz_hist_q <= 9'h000;
        end else if (bit_in.valid) begin
            prev_raw_q <= bit_in.data;
            nrz_hist_q <= {nrz_hist_q[7:0], nrz};
        end
    end

    // ======================================================================
    // Output stage, one cycle behind the input strobe.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bit_out <= '0;
        end else begin
            bit_out.valid <= bit_in.valid;
            bit_out.data <= bypass ? bit_in.data : descr;
        end
    end

endmodule

`default_nettype wire

// File: dv/sdi_rx_chk.sv
`timescale 1ns/1ps
`default_nettype none
module sdi_rx_chk #(
    parameter int unsigned LOCK_CYCLES = 9500
) (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Bus
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    // Stream and indications
    input wire logic ser_data,
    input wire logic ser_valid,
    input wire logic [9:0] par_word,
    input wire logic par_word_clk,
    input wire logic line_timing,
    input wire logic lock,
    input wire logic carrier_present_n,
    input wire logic equalizer_bypass_sel
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    logic last_q, seen_q, take, flip;
    logic [8:0] idle_q;
    logic [31:0] run_q;
    assign take = hsel && hready && htrans[1];
    assign flip = ser_valid && seen_q && (ser_data != last_q);
    // The first bit after reset is not a transition, so no false carrier is seen.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            last_q <= 1'b0;
            seen_q <= 1'b0;
            idle_q <= 9'h0;
            run_q <= 32'h0;
        end else begin
            if (ser_valid) begin
                last_q <= ser_data;
                seen_q <= 1'b1;
            end
            idle_q <= flip ? 9'h0 : idle_q + {8'h0, idle_q != 9'h1ff};
            run_q <= carrier_present_n ? 32'h0 : run_q + 32'h1;
        end
    end
    // ==========
    // Checks.
    sequence ctrl_wr;
        take && hwrite && (haddr[7:0] == 8'h00);
    endsequence
    sequence clk_hi;
        par_word_clk [*5];
    endsequence
    property p_eq;
        logic v;
        ctrl_wr ##1 (1'b1, v = hwdata[1]) |-> ##[1:2] equalizer_bypass_sel == v;
    endproperty
    a_bus_okay: assert property (hreadyout && !hresp)
        else $error("bus not ready or not okay");
    a_eq_follow: assert property (p_eq)
        else $error("equalizer select missed write");
    a_unmapped_zero: assert property (take && !hwrite && haddr[7:0] >= 8'h10 |=> hrdata == 32'h0)
        else $error("unmapped read not zero");
    a_word_clk_low: assert property (!$stable(par_word) |-> !par_word_clk)
        else $error("word changed with word clock high");
    a_clk_high_run: assert property ($rose(par_word_clk) |-> clk_hi)
        else $error("word clock high too short");
    a_line_flag: assert property ($changed(line_timing) |-> line_timing == par_word[6])
        else $error("line flag disagrees with header");
    a_carrier_lost: assert property (idle_q > 9'd252 |-> carrier_present_n)
        else $error("carrier kept without transitions");
    a_carrier_seen: assert property (flip |-> ##[1:3] !carrier_present_n)
        else $error("carrier missed a transition");
    a_lock_late: assert property ($rose(lock) |-> run_q >= LOCK_CYCLES)
        else $error("lock too early");
    a_lock_drop: assert property ($rose(carrier_present_n) |-> ##[0:2] !lock)
        else $error("lock kept after carrier loss");
endmodule
bind sdi_rx_deserializer sdi_rx_chk #(.LOCK_CYCLES(LOCK_CYCLES)) u_chk (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .ser_data(ser_data), .ser_valid(ser_valid),
    .par_word(par_word), .par_word_clk(par_word_clk), .line_timing(line_timing),
    .lock(lock), .carrier_present_n(carrier_present_n),
    .equalizer_bypass_sel(equalizer_bypass_sel)
);
`default_nettype wire

// File: dv/sdi_video_source.sv
`timescale 1ns/1ps
`default_nettype none
module sdi_video_source (
    // Clock
    input wire logic hclk,
    // Serial stream
    output logic ser_data,
    output logic ser_valid
);
    int unsigned gap = 0;
    logic [8:0] scr_q = 9'h0;
    logic nrzi_q = 1'b0;
    initial begin
        ser_data = 1'b0;
        ser_valid = 1'b0;
    end
    // ==========
    // Coder history restarts with the receiver's reset.
    task automatic restart();
        scr_q = 9'h0;
        nrzi_q = 1'b0;
    endtask
    // The line toggles between strobes so a stale bit is never reused.
    task automatic send_word(input logic [9:0] w, input logic raw);
        logic s;
        for (int i = 0; i < 10; i++) begin
            s = w[i] ^ scr_q[3] ^ scr_q[8];
            scr_q = {scr_q[7:0], s};
            nrzi_q = nrzi_q ^ s;
            @(posedge hclk);
            ser_data <= raw ? w[i] : nrzi_q;
            ser_valid <= 1'b1;
            @(posedge hclk);
            ser_valid <= 1'b0;
            ser_data <= ~ser_data;
            repeat (gap) begin
                @(posedge hclk);
                ser_data <= ~ser_data;
            end
        end
    endtask
endmodule
`default_nettype wire

// File: dv/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, rd_dphase, irq;
    logic ser_data, ser_valid, par_word_clk, line_timing, lock;
    logic carrier_present_n, equalizer_bypass_sel;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [9:0] par_word;
    int num_errors = 0;
    int samples_checked = 0;
    int cyc = 0;
    logic [31:0] rd_q[$];
    logic [9:0] word_q[$];
    sdi_rx_deserializer #(.LOCK_CYCLES(20)) u_dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .ser_data(ser_data),
        .ser_valid(ser_valid), .par_word(par_word), .par_word_clk(par_word_clk),
        .line_timing(line_timing), .lock(lock), .carrier_present_n(carrier_present_n),
        .equalizer_bypass_sel(equalizer_bypass_sel), .irq(irq));
    sdi_video_source u_src (.hclk(hclk), .ser_data(ser_data), .ser_valid(ser_valid));
    initial begin
        hclk = 1'b0;
        forever #2 hclk = ~hclk;
    end
    // ==========
    // Shared tasks.
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic close_out();
        $display("compared %0d mismatched %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= wr;
        haddr <= {24'h0, a};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        rd_dphase <= !wr;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd_dphase <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        rd_q.push_back(e);
        ahb(1'b0, a, 32'h0);
    endtask
    function automatic logic [9:0] rnd();
        return 10'($urandom) | 10'h021;
    endfunction
    task automatic send(input logic [9:0] w, input logic raw, input logic note);
        if (note) word_q.push_back(w);
        u_src.gap = $urandom_range(3, 0);
        u_src.send_word(w, raw);
    endtask
    task automatic frame(input logic raw, input logic [9:0] xyz, input logic pre,
            input logic tail);
        // A fresh alignment shows the word held since reset at its first word clock.
        if (!pre) word_q.push_back(10'h000);
        send(10'h3ff, raw, pre);
        send(10'h000, raw, pre);
        send(10'h000, raw, pre);
        send(xyz, raw, 1'b1);
        repeat (4) send(rnd(), raw, 1'b1);
        send(rnd(), raw, tail);
    endtask
    // ==========
    // Result watchers.
    always @(posedge hclk) begin
        cyc <= cyc + 1;
        if (rd_dphase === 1'b1) check(hrdata, rd_q.pop_front());
        if (cyc == 20000) begin
            num_errors++;
            close_out();
        end
    end
    always @(posedge par_word_clk) begin
        check({22'h0, par_word}, {22'h0, word_q.pop_front()});
    end
    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        htrans = 2'b00;
        hwrite = 1'b0;
        haddr = 32'h0;
        hwdata = 32'h0;
        hsize = 3'h2;
        rd_dphase = 1'b0;
        void'($urandom(10916));
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        check({26'h0, hreadyout, hresp, par_word_clk, lock, carrier_present_n, irq}, 32'h22);
        rd(8'h00, 32'h0);
        rd(8'h04, 32'h0);
        rd(8'h0c, 32'h0);
        ahb(1'b1, 8'h00, 32'h1);
        ahb(1'b1, 8'h00, 32'h2);
        ahb(1'b1, 8'h40, 32'hffffffff);
        ahb(1'b1, 8'h0c, 32'h1);
        rd(8'h00, 32'h2);
        rd(8'h40, 32'h0);
        rd(8'h0c, 32'h1);
        check({31'h0, equalizer_bypass_sel}, 32'h1);
        $display("registers done");
        u_src.restart();
        repeat (6) send(rnd(), 1'b0, 1'b0);
        frame(1'b0, 10'h274, 1'b0, 1'b1);
        check({30'h0, line_timing, irq}, 32'h3);
        ahb(1'b1, 8'h08, 32'h1);
        repeat (2) @(posedge hclk);
        check({31'h0, irq}, 32'h0);
        frame(1'b0, 10'h200, 1'b1, 1'b0);
        check({29'h0, line_timing, lock, irq}, 32'h2);
        repeat (260) @(posedge hclk);
        check({30'h0, carrier_present_n, lock}, 32'h2);
        rd(8'h08, 32'he);
        check(32'(word_q.size()), 32'h0);
        $display("decoded stream done");
        hresetn <= 1'b0;
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        u_src.restart();
        ahb(1'b1, 8'h00, 32'h3);
        repeat (6) send(rnd(), 1'b1, 1'b0);
        frame(1'b1, 10'h274, 1'b0, 1'b0);
        repeat (4) @(posedge hclk);
        check(32'(word_q.size()), 32'h0);
        $display("bypass stream done");
        close_out();
    end
endmodule
`default_nettype wire
